// *** hdl/dim_img_ram.sv ***
// image memory: 16-bit words, byte lane writes, registered read data
`timescale 1ns/1ns
module dim_img_ram (
	// clock
	input  wire logic        mclk,
	// write port
	input  wire logic        wr_en,
	input  wire logic [4:0]  wr_addr,
	input  wire logic [1:0]  wr_be,
	input  wire logic [15:0] wr_data,
	// read port
	input  wire logic [4:0]  rd_addr,
	output logic      [15:0] rd_data_q
);

	logic [15:0] mem [0:dim_pkg::IMG_WORDS-1];

	// lane 0 is the lower byte address
	always_ff @(posedge mclk) begin
		if (wr_en && wr_be[0]) begin
			mem[wr_addr][7:0] <= wr_data[7:0];
		end
		if (wr_en && wr_be[1]) begin
			mem[wr_addr][15:8] <= wr_data[15:8];
		end
	end

	always_ff @(posedge mclk) begin
		rd_data_q <= mem[rd_addr];
	end

endmodule : dim_img_ram

// *** hdl/dim_mapper.sv ***
// top: digital input image mapper with avalon-mm register slave
`timescale 1ns/1ns

// How it works
// - image held in word-aligned 16-bit words
// - even byte address is the low byte
// - one signal bit per input channel
// - digital bytes follow all analog data
// - slot byte follows all earlier slots' bytes
// - diagnostic modules add one fault bit/channel
// - one-channel diag: signal bit0, fault bit1
// - two-channel: channel1 bit0, channel2 bit1
// - two-channel diag: signals 0-1, faults 2-3
// - ack module flags fault immediately on arrival
// - cleared fault stays set until acknowledged
// - acks on output bits 2-3, bits 0-1 zero
// - four-channel: channels 1-4 on bits 0-3
// - eight-channel: channels 1-8 on bits 0-7
module dim_mapper (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// avalon-mm slave
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [3:0]  avs_byteenable,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// field side, eight channels per slot, slot 0 in the low byte
	input  wire logic [63:0] channel_signal_bit,
	input  wire logic [63:0] channel_fault_bit,
	// output image toward the modules, one byte per slot
	output logic      [63:0] out_img_q
);

	////////////////////////////////////////////////////////////////////////////
	// functions

	function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
	                                         input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge_be

	function automatic dim_pkg::dim_mod_t slot_kind(input logic [23:0] types, input logic [2:0] s);
		logic [2:0] code;
		code = types[s*3 +: 3];
		if (code > 3'h6) begin
			return dim_pkg::MOD_NONE;
		end
		return dim_pkg::dim_mod_t'(code);
	endfunction : slot_kind

	// one input byte per module; unlisted positions stay zero
	function automatic logic [7:0] pack_byte(input dim_pkg::dim_mod_t k, input logic [7:0] sig,
	                                         input logic [7:0] diag);
		logic [7:0] b;
		b = 8'h00;
		unique case (k)
			dim_pkg::MOD_NONE:     b = 8'h00;
			dim_pkg::MOD_1CH_DIAG: b = {6'h00, diag[0], sig[0]};
			dim_pkg::MOD_2CH:      b = {6'h00, sig[1:0]};
			dim_pkg::MOD_2CH_DIAG,
			dim_pkg::MOD_2CH_ACK:  b = {4'h0, diag[1:0], sig[1:0]};
			dim_pkg::MOD_4CH:      b = {4'h0, sig[3:0]};
			dim_pkg::MOD_8CH:      b = sig;
		endcase
		return b;
	endfunction : pack_byte

	function automatic logic is_image(input logic [7:0] a);
		return a >= dim_pkg::OFS_IMG_BASE;
	endfunction : is_image

	////////////////////////////////////////////////////////////////////////////
	// declarations

	dim_pkg::dim_bus_st_t bus_st_q;
	dim_pkg::dim_map_st_t map_st_q;
	logic [31:0]          ctrl_q;
	logic [23:0]          slot_type_q;
	logic [15:0]          ack_q;
	logic [63:0]          lock_q;
	logic [2:0]           slot_q;
	logic [6:0]           ptr_q;
	logic [6:0]           dig_cnt_q;
	logic                 ovf_q;
	logic                 scan_ovf_q;
	logic [7:0]           addr_q;
	logic                 is_wr_q;
	logic [3:0]           be_q;
	logic [31:0]          wdata_q;
	logic [31:0]          reg_rdata;
	logic [15:0]          ram_rdata;
	logic                 bus_mem_rd;
	logic                 bus_mem_wr;
	logic                 map_wr;
	logic                 ram_wr_en;
	logic [4:0]           ram_wr_addr;
	logic [1:0]           ram_wr_be;
	logic [15:0]          ram_wr_data;
	logic [4:0]           ram_rd_addr;
	logic [6:0]           ana_start;
	logic [63:0]          eff_sig;
	logic [7:0]           cur_byte;
	dim_pkg::dim_mod_t    cur_kind;

	////////////////////////////////////////////////////////////////////////////
	// avalon slave sequencer

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bus_st_q        <= dim_pkg::BUS_IDLE;
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
			addr_q          <= 8'h00;
			is_wr_q         <= 1'b0;
			be_q            <= 4'h0;
			wdata_q         <= 32'h0000_0000;
		end else begin
			unique case (bus_st_q)
				dim_pkg::BUS_IDLE: begin
					avs_waitrequest <= 1'b1;
					if (avs_read || avs_write) begin
						addr_q  <= avs_address;
						is_wr_q <= avs_write;
						be_q    <= avs_byteenable;
						wdata_q <= avs_writedata;
						if (avs_read && is_image(avs_address)) begin
							bus_st_q <= dim_pkg::BUS_MEM;
						end else begin
							avs_readdata    <= avs_read ? reg_rdata : 32'h0000_0000;
							avs_waitrequest <= 1'b0;
							bus_st_q        <= dim_pkg::BUS_DONE;
						end
					end
				end
				dim_pkg::BUS_MEM: begin
					avs_readdata    <= {16'h0000, ram_rdata};
					avs_waitrequest <= 1'b0;
					bus_st_q        <= dim_pkg::BUS_DONE;
				end
				dim_pkg::BUS_DONE: begin
					avs_waitrequest <= 1'b1;
					bus_st_q        <= dim_pkg::BUS_IDLE;
				end
			endcase
		end
	end

	// register read mux, unmapped offsets read zero
	always_comb begin
		reg_rdata = 32'h0000_0000;
		unique case (avs_address)
			dim_pkg::OFS_CTRL:       reg_rdata = ctrl_q;
			dim_pkg::OFS_STATUS:     reg_rdata = {16'h0000, 1'b0, dig_cnt_q, 6'h00, ovf_q,
			                                      map_st_q != dim_pkg::MAP_IDLE};
			dim_pkg::OFS_SLOT_TYPE:  reg_rdata = {8'h00, slot_type_q};
			dim_pkg::OFS_ACK:        reg_rdata = {16'h0000, ack_q};
			dim_pkg::OFS_OUT_IMG_LO: reg_rdata = out_img_q[31:0];
			dim_pkg::OFS_OUT_IMG_HI: reg_rdata = out_img_q[63:32];
			default:                 reg_rdata = 32'h0000_0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// software registers, written at the edge where waitrequest is low

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q      <= dim_pkg::CTRL_RST;
			slot_type_q <= dim_pkg::SLOT_TYPE_RST;
			ack_q       <= dim_pkg::ACK_RST;
		end else if (bus_st_q == dim_pkg::BUS_DONE && is_wr_q) begin
			unique case (addr_q)
				dim_pkg::OFS_CTRL:      ctrl_q      <= merge_be(ctrl_q, wdata_q, be_q);
				dim_pkg::OFS_SLOT_TYPE: slot_type_q <= 24'(merge_be({8'h00, slot_type_q}, wdata_q, be_q));
				dim_pkg::OFS_ACK:       ack_q       <= 16'(merge_be({16'h0000, ack_q}, wdata_q, be_q));
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// fault lockout for acknowledge modules

	// fault sets at once and wins over a concurrent acknowledge
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			lock_q <= 64'h0000_0000_0000_0000;
		end else begin
			for (int s = 0; s < dim_pkg::NUM_SLOTS; s++) begin
				for (int c = 0; c < dim_pkg::CH_PER_SLOT; c++) begin
					if (slot_kind(slot_type_q, 3'(s)) != dim_pkg::MOD_2CH_ACK || c > 1) begin
						lock_q[s*8+c] <= 1'b0;
					end else if (channel_fault_bit[s*8+c]) begin
						lock_q[s*8+c] <= 1'b1;
					end else if (ack_q[s*2+(c%2)]) begin
						lock_q[s*8+c] <= 1'b0;
					end
				end
			end
		end
	end

	// a locked channel reads inactive
	always_comb begin
		eff_sig = channel_signal_bit & ~lock_q;
	end

	// output image: acknowledge bits at 2 and 3, everything else zero
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			out_img_q <= 64'h0000_0000_0000_0000;
		end else begin
			for (int s = 0; s < dim_pkg::NUM_SLOTS; s++) begin
				if (slot_kind(slot_type_q, 3'(s)) == dim_pkg::MOD_2CH_ACK) begin
					out_img_q[s*8 +: 8] <= {4'h0, ack_q[s*2 +: 2], 2'b00};
				end else begin
					out_img_q[s*8 +: 8] <= 8'h00;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// image builder

	// digital data starts on the word after the analog block
	always_comb begin
		ana_start = ctrl_q[dim_pkg::CTRL_ANA_LSB +: 7] + {6'h00, ctrl_q[dim_pkg::CTRL_ANA_LSB]};
		cur_kind  = slot_kind(slot_type_q, slot_q);
		cur_byte  = pack_byte(cur_kind, eff_sig[slot_q*8 +: 8],
		                      (cur_kind == dim_pkg::MOD_2CH_ACK) ? lock_q[slot_q*8 +: 8]
		                                                         : channel_fault_bit[slot_q*8 +: 8]);
	end

	// the bus owns the write port while it writes the image; image reads use the read port and bus_mem_rd is not used
	assign bus_mem_rd = (bus_st_q == dim_pkg::BUS_IDLE) && avs_read && is_image(avs_address);
	assign bus_mem_wr = (bus_st_q == dim_pkg::BUS_DONE) && is_wr_q && is_image(addr_q);
	assign map_wr     = !bus_mem_wr && ptr_q < dim_pkg::IMG_BYTES &&
	                    ((map_st_q == dim_pkg::MAP_SCAN && cur_kind != dim_pkg::MOD_NONE) ||
	                     map_st_q == dim_pkg::MAP_PAD);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			map_st_q   <= dim_pkg::MAP_IDLE;
			slot_q     <= 3'h0;
			ptr_q      <= 7'h00;
			dig_cnt_q  <= 7'h00;
			ovf_q      <= 1'b0;
			scan_ovf_q <= 1'b0;
		end else begin
			unique case (map_st_q)
				dim_pkg::MAP_IDLE: begin
					if (ctrl_q[dim_pkg::CTRL_EN_BIT]) begin
						slot_q     <= 3'h0;
						ptr_q      <= ana_start;
						scan_ovf_q <= 1'b0;
						map_st_q   <= dim_pkg::MAP_SCAN;
					end
				end
				dim_pkg::MAP_SCAN: begin
					if (!bus_mem_wr) begin
						if (cur_kind != dim_pkg::MOD_NONE) begin
							if (ptr_q >= dim_pkg::IMG_BYTES) begin
								scan_ovf_q <= 1'b1;
							end else begin
								ptr_q <= ptr_q + 7'h01;
							end
						end
						if (slot_q == 3'(dim_pkg::NUM_SLOTS - 1)) begin
							map_st_q <= dim_pkg::MAP_PAD;
						end
						slot_q <= slot_q + 3'h1;
					end
				end
				dim_pkg::MAP_PAD: begin
					if (!bus_mem_wr) begin
						map_st_q <= dim_pkg::MAP_FIN;
					end
				end
				dim_pkg::MAP_FIN: begin
					dig_cnt_q <= ptr_q - ana_start;
					ovf_q     <= scan_ovf_q;
					map_st_q  <= dim_pkg::MAP_IDLE;
				end
			endcase
		end
	end

	// pad writes a zero lane only when the last word is half used
	always_comb begin
		ram_wr_en   = 1'b0;
		ram_wr_addr = 5'h00;
		ram_wr_be   = 2'b00;
		ram_wr_data = 16'h0000;
		if (bus_mem_wr) begin
			ram_wr_en   = 1'b1;
			ram_wr_addr = addr_q[6:2] - 5'h10;
			ram_wr_be   = be_q[1:0];
			ram_wr_data = wdata_q[15:0];
		end else if (map_wr) begin
			ram_wr_en   = (map_st_q == dim_pkg::MAP_SCAN) || ptr_q[0];
			ram_wr_addr = ptr_q[5:1];
			ram_wr_be   = ptr_q[0] ? 2'b10 : 2'b01;
			ram_wr_data = (map_st_q == dim_pkg::MAP_SCAN) ? {cur_byte, cur_byte} : 16'h0000;
		end
		ram_rd_addr = avs_address[6:2] - 5'h10;
	end

	////////////////////////////////////////////////////////////////////////////
	// image memory

	dim_img_ram u_img (
		.mclk      (mclk),
		.wr_en     (ram_wr_en),
		.wr_addr   (ram_wr_addr),
		.wr_be     (ram_wr_be),
		.wr_data   (ram_wr_data),
		.rd_addr   (ram_rd_addr),
		.rd_data_q (ram_rdata)
	);

endmodule : dim_mapper

// *** hdl/dim_pkg.sv ***
// package: constants, types and register map of the digital input image mapper
package dim_pkg;

	// node and image geometry
	localparam int                  NUM_SLOTS      = 8;
	localparam int                  SLOT_IDX_W     = 3;
	localparam int                  CH_PER_SLOT    = 8;
	localparam int                  IMG_WORDS      = 32;
	localparam int                  IMG_AW         = 5;
	localparam int                  IMG_BYTE_AW    = 6;
	localparam logic [6:0]          IMG_BYTES      = 7'h40;

	// register byte offsets on the avalon slave
	localparam logic [7:0]          OFS_CTRL       = 8'h00;
	localparam logic [7:0]          OFS_STATUS     = 8'h04;
	localparam logic [7:0]          OFS_SLOT_TYPE  = 8'h08;
	localparam logic [7:0]          OFS_ACK        = 8'h0C;
	localparam logic [7:0]          OFS_OUT_IMG_LO = 8'h10;
	localparam logic [7:0]          OFS_OUT_IMG_HI = 8'h14;
	localparam logic [7:0]          OFS_IMG_BASE   = 8'h40;

	// field positions
	localparam int                  CTRL_EN_BIT    = 0;
	localparam int                  CTRL_ANA_LSB   = 8;
	localparam int                  STAT_BUSY_BIT  = 0;
	localparam int                  STAT_OVF_BIT   = 1;
	localparam int                  STAT_CNT_LSB   = 8;
	localparam int                  ACK_POS_LO     = 2;

	// reset values
	localparam logic [31:0]         CTRL_RST       = 32'h0000_0000;
	localparam logic [23:0]         SLOT_TYPE_RST  = 24'h00_0000;
	localparam logic [15:0]         ACK_RST        = 16'h0000;

	// kind of module plugged into each slot
	typedef enum logic [2:0] {
		MOD_NONE     = 3'h0,
		MOD_1CH_DIAG = 3'h1,
		MOD_2CH      = 3'h2,
		MOD_2CH_DIAG = 3'h3,
		MOD_2CH_ACK  = 3'h4,
		MOD_4CH      = 3'h5,
		MOD_8CH      = 3'h6
	} dim_mod_t;

	// bus side sequencer, gray along idle-mem-done
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_MEM  = 2'b01,
		BUS_DONE = 2'b11
	} dim_bus_st_t;

	// image builder, gray along idle-scan-pad-fin
	typedef enum logic [1:0] {
		MAP_IDLE = 2'b00,
		MAP_SCAN = 2'b01,
		MAP_PAD  = 2'b11,
		MAP_FIN  = 2'b10
	} dim_map_st_t;

endpackage : dim_pkg

// *** verif/dim_field.sv ***
// field model: input modules presenting signal and fault levels
`timescale 1ns/1ns
module dim_field (
	// clock
	input  wire logic        mclk,
	// levels requested by the bench
	input  wire logic [63:0] sig_req,
	input  wire logic [63:0] flt_req,
	// levels on the local bus
	output logic      [63:0] sig_q,
	output logic      [63:0] flt_q
);
	always_ff @(posedge mclk) begin
		sig_q <= sig_req;
		flt_q <= flt_req;
	end
endmodule : dim_field

// *** verif/dim_mapper_asserts.sv ***
// checker: bus timing and output image properties of the mapper
`timescale 1ns/1ns
module dim_chk (
	// clock and reset
	input wire logic        mclk,
	input wire logic        rst_n,
	// avalon-mm slave
	input wire logic [7:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// field and output image
	input wire logic [63:0] channel_signal_bit,
	input wire logic [63:0] channel_fault_bit,
	input wire logic [63:0] out_img_q
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////
	a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low longer than one cycle");
	a_write_answer: assert property ($rose(avs_write) |=> !avs_waitrequest)
		else $error("write not answered in one cycle");
	a_reg_read: assert property ($rose(avs_read) && avs_address < 8'h40 |=> !avs_waitrequest)
		else $error("register read not answered in one cycle");
	a_img_read: assert property ($rose(avs_read) && avs_address inside {[8'h40:8'hBC]}
		|=> avs_waitrequest ##1 !avs_waitrequest) else $error("image read answer not in second cycle");
	a_write_rdata: assert property (avs_write && !avs_waitrequest |-> avs_readdata == 32'h0)
		else $error("write answer carries data");
	a_unmapped_zero: assert property (
		avs_read && !avs_waitrequest && avs_address inside {[8'h18:8'h3C]} |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	a_word_high: assert property (
		avs_read && !avs_waitrequest && avs_address inside {[8'h40:8'hBC]} |-> avs_readdata[31:16] == 16'h0)
		else $error("image word wider than 16 bits");
	a_out_spare: assert property ((out_img_q & 64'hF3F3F3F3F3F3F3F3) == 64'h0)
		else $error("output image bit outside acknowledge positions set");
	a_out_readback: assert property (
		avs_read && !avs_waitrequest && avs_address == 8'h10 |-> avs_readdata == out_img_q[31:0])
		else $error("output image readback mismatch");
endmodule : dim_chk
bind dim_mapper dim_chk dim_chk_u (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.channel_signal_bit(channel_signal_bit), .channel_fault_bit(channel_fault_bit), .out_img_q(out_img_q));

// *** verif/dim_mapper_test.sv ***
// testbench: register and image accesses with expected values
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("Error at %0t: got %h expected %h", $time, g, e); end end
module dim_mapper_test;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [63:0] sig_req = 64'hFF_FF_A5_F6_F3_F1_FE_FF;
	logic [63:0] flt_req = 64'h00_00_00_00_00_F2_FF_01;
	logic [63:0] sig;
	logic [63:0] flt;
	logic [63:0] out_img;
	logic [31:0] q;
	int          mismatches = 0;
	int          num_checks = 0;
	always #10 mclk = ~mclk;
	dim_field field_u (.mclk(mclk), .sig_req(sig_req), .flt_req(flt_req), .sig_q(sig), .flt_q(flt));
	dim_mapper dut_u (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_byteenable(4'hF), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .channel_signal_bit(sig),
		.channel_fault_bit(flt), .out_img_q(out_img));
	////////////////////////////////////////////////////////////////////////
	task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= rd;
		avs_write <= !rd;
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		if (n >= 50) mismatches++;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge mclk);
	endtask : bus
	// rereads an image word until it reads the expected value, 40 reads at most
	task automatic poll_chk(input logic [7:0] a, input logic [15:0] e);
		int n;
		n = 0;
		do begin
			bus(1'b1, a, 32'h0);
			n++;
		end while (q[15:0] !== e && n < 40);
		`CHK(q, {16'h0, e})
	endtask : poll_chk
	task automatic end_test(input string s);
		$display("test %s done", s);
	endtask : end_test
	task wrap_up;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : wrap_up
	////////////////////////////////////////////////////////////////////////
	initial begin
		#400000;
		mismatches++;
		wrap_up();
	end
	initial begin
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		bus(1'b1, 8'h00, 32'h0);
		`CHK(q, 32'h0)
		bus(1'b1, 8'h08, 32'h0);
		`CHK(q, 32'h0)
		bus(1'b1, 8'h10, 32'h0);
		`CHK(q, 32'h0)
		end_test("reset");
		// analog words, then slots 1ch diag, 2ch, 2ch diag, ack, 4ch, 8ch, none, code 7
		bus(1'b0, 8'h40, 32'h1234);
		bus(1'b0, 8'h44, 32'hABCD);
		bus(1'b0, 8'h08, {8'h0, 3'h7, 3'h0, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1});
		bus(1'b0, 8'h00, 32'h0000_0301);
		poll_chk(8'h48, 16'h0203);
		poll_chk(8'h4C, 16'h0309);
		poll_chk(8'h50, 16'hA506);
		poll_chk(8'h40, 16'h1234);
		poll_chk(8'h44, 16'hABCD);
		bus(1'b1, 8'h04, 32'h0);
		`CHK(q & 32'h0000_7F02, 32'h0000_0600)
		end_test("map");
		flt_req <= flt_req | 64'h0100_0000;
		poll_chk(8'h4C, 16'h0609);
		flt_req <= flt_req & ~64'h0100_0000;
		repeat (40) bus(1'b1, 8'h04, 32'h0);
		poll_chk(8'h4C, 16'h0609);
		bus(1'b0, 8'h0C, 32'h0044);
		poll_chk(8'h4C, 16'h0309);
		bus(1'b1, 8'h10, 32'h0);
		`CHK(q, 32'h0400_0000)
		`CHK(out_img, 64'h0000_0000_0400_0000)
		end_test("ack");
		// drop the 8ch slot: odd byte count, high lane of the last word is zeroed
		bus(1'b0, 8'h08, {8'h0, 3'h7, 3'h0, 3'h0, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1});
		poll_chk(8'h50, 16'h0006);
		poll_chk(8'h4C, 16'h0309);
		repeat (10) bus(1'b1, 8'h04, 32'h0);
		`CHK(q & 32'h0000_7F02, 32'h0000_0500)
		end_test("pad");
		// analog block of 62 bytes: two slot bytes fit, the rest overflow
		bus(1'b0, 8'h00, 32'h0000_3E01);
		poll_chk(8'hBC, 16'h0203);
		repeat (10) bus(1'b1, 8'h04, 32'h0);
		`CHK(q & 32'h0000_7F02, 32'h0000_0202)
		end_test("overflow");
		bus(1'b0, 8'h20, 32'hFFFF_FFFF);
		bus(1'b1, 8'h20, 32'h0);
		`CHK(q, 32'h0)
		end_test("bus");
		wrap_up();
	end
endmodule : dim_mapper_test
